// ### logic/scc_clock_select.sv
// clock source select, oscillator control and glitch-free switch with wishbone registers
`timescale 1ns/1ns
module scc_clock_select #(
    parameter int STAB_CYC = scc_pkg::HS_STAB_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic hs_int_clk_i,
    input wire logic hs_sys_clk_i,
    input wire logic sub_clk_i,
    input wire logic ls_fixed_i,
    input wire logic stop_mode_i,
    output scc_pkg::scc_pin_ctrl_t pins_o,
    output scc_pkg::scc_clk_out_t clks_o,
    output logic hs_int_osc_run_o,
    output logic ls_osc_run_o
);
    import scc_pkg::*;

    // clock inputs arrive from other domains: two flops each
    logic [2:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    always_comb begin
        nxt_sync1 = {sub_clk_i, hs_sys_clk_i, hs_int_clk_i};
        nxt_sync2 = sync1_ff;
    end
    always_ff @(posedge clk_i) begin
        sync1_ff <= nxt_sync1;
        sync2_ff <= nxt_sync2;
    end
    logic [1:0] strap_s1_ff, strap_s2_ff, nxt_strap_s1, nxt_strap_s2;
    always_comb begin
        nxt_strap_s1 = {stop_mode_i, ls_fixed_i};
        nxt_strap_s2 = strap_s1_ff;
    end
    always_ff @(posedge clk_i) begin
        strap_s1_ff <= nxt_strap_s1;
        strap_s2_ff <= nxt_strap_s2;
    end

    // registers
    logic [7:0] osc_mode_ff, main_osc_ff, main_mode_ff, proc_clk_ff, int_osc_ff;
    logic [7:0] nxt_osc_mode, nxt_main_osc, nxt_main_mode, nxt_proc_clk, nxt_int_osc;
    logic ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic ls_fixed_ff, nxt_ls_fixed;
    logic strap_taken_ff, nxt_strap_taken;
    scc_src_t cpu_src_ff, nxt_cpu_src;
    scc_src_t per_src_ff, nxt_per_src;
    logic hs_stable_ff, nxt_hs_stable;
    logic [15:0] stab_cnt_ff, nxt_stab_cnt;

    function automatic logic [7:0] wb_merge(input logic [7:0] cur, input logic [31:0] d,
                                            input logic lane);
        wb_merge = lane ? d[7:0] : cur;
    endfunction

    logic wb_req;
    logic [4:0] adr;
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign adr = wb_adr_i[4:0];

    always_comb begin
        nxt_osc_mode = osc_mode_ff;
        nxt_main_osc = main_osc_ff;
        nxt_main_mode = main_mode_ff;
        nxt_proc_clk = proc_clk_ff;
        nxt_int_osc = int_osc_ff;
        nxt_ack = wb_req;
        nxt_rdat = 32'h0000_0000;
        nxt_ls_fixed = ls_fixed_ff;
        nxt_strap_taken = 1'b1;
        if (!strap_taken_ff) begin
            nxt_ls_fixed = strap_s2_ff[0];
        end
        if (wb_req && wb_we_i) begin
            unique case (adr)
                OFF_OSC_MODE: nxt_osc_mode = wb_merge(osc_mode_ff, wb_dat_i, wb_sel_i[0]);
                OFF_MAIN_OSC: nxt_main_osc = wb_merge(main_osc_ff, wb_dat_i, wb_sel_i[0]);
                OFF_MAIN_MODE: nxt_main_mode = wb_merge(main_mode_ff, wb_dat_i, wb_sel_i[0]);
                OFF_PROC_CLK: nxt_proc_clk = wb_merge(proc_clk_ff, wb_dat_i, wb_sel_i[0]);
                OFF_INT_OSC: nxt_int_osc = wb_merge(int_osc_ff, wb_dat_i, wb_sel_i[0]);
                default: ;
            endcase
            // status flags are not writable
            nxt_main_mode[B_MAIN_FLAG] = 1'b0;
            nxt_proc_clk[B_SUB_FLAG] = 1'b0;
            nxt_int_osc[B_HS_STABLE] = 1'b0;
            // prohibited divider codes keep the old value
            if (nxt_proc_clk[B_DIV_HI:0] > DIV_MAX) begin
                nxt_proc_clk[B_DIV_HI:0] = proc_clk_ff[B_DIV_HI:0];
            end
        end
        if (wb_req && !wb_we_i) begin
            unique case (adr)
                OFF_OSC_MODE: nxt_rdat[7:0] = osc_mode_ff;
                OFF_MAIN_OSC: nxt_rdat[7:0] = main_osc_ff;
                OFF_MAIN_MODE: begin
                    nxt_rdat[7:0] = main_mode_ff;
                    nxt_rdat[B_MAIN_FLAG] = (cpu_src_ff == SRC_HS_SYS);
                end
                OFF_PROC_CLK: begin
                    nxt_rdat[7:0] = proc_clk_ff;
                    nxt_rdat[B_SUB_FLAG] = (cpu_src_ff == SRC_SUB);
                end
                OFF_INT_OSC: begin
                    nxt_rdat[7:0] = int_osc_ff;
                    nxt_rdat[B_HS_STABLE] = hs_stable_ff;
                end
                default: nxt_rdat = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_mode_ff <= RST_OSC_MODE;
            main_osc_ff <= RST_MAIN_OSC;
            main_mode_ff <= RST_MAIN_MODE;
            proc_clk_ff <= RST_PROC_CLK;
            int_osc_ff <= RST_INT_OSC;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
            ls_fixed_ff <= 1'b0;
            strap_taken_ff <= 1'b0;
        end else begin
            osc_mode_ff <= nxt_osc_mode;
            main_osc_ff <= nxt_main_osc;
            main_mode_ff <= nxt_main_mode;
            proc_clk_ff <= nxt_proc_clk;
            int_osc_ff <= nxt_int_osc;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
            ls_fixed_ff <= nxt_ls_fixed;
            strap_taken_ff <= nxt_strap_taken;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // oscillator and pin control
    logic sub_start, sub_ext, sub_en;
    assign sub_start = proc_clk_ff[B_SUB_START];
    assign sub_ext = osc_mode_ff[B_SUB_EXT];
    assign sub_en = osc_mode_ff[B_SUB_EN];

    scc_pin_ctrl_t pins_ff, nxt_pins;
    logic hs_run_ff, nxt_hs_run, ls_run_ff, nxt_ls_run;
    always_comb begin
        // sub enable or the sub start bit gates the subclock; stop mode leaves the pins alone and only stops the internal high-speed oscillator
        nxt_pins.sub_crystal = sub_start || (!sub_ext && sub_en);
        nxt_pins.sub_ext_input = !sub_start && sub_ext && sub_en;
        nxt_pins.sub_in_port = !nxt_pins.sub_crystal;
        nxt_pins.main_osc_run = !main_osc_ff[B_MAIN_STOP] && osc_mode_ff[B_MAIN_PIN_EN];
        nxt_pins.main_ext_input = osc_mode_ff[B_MAIN_EXT];
        nxt_pins.amp_gain_high = osc_mode_ff[B_AMP_HIGH];
        nxt_hs_run = !int_osc_ff[B_HS_STOP] && !strap_s2_ff[1];
        nxt_ls_run = ls_fixed_ff || !int_osc_ff[B_LS_STOP];
    end

    // stabilization count for internal high-speed oscillator
    always_comb begin
        nxt_stab_cnt = stab_cnt_ff;
        nxt_hs_stable = hs_stable_ff;
        if (!hs_run_ff) begin
            nxt_stab_cnt = 16'h0000;
            nxt_hs_stable = 1'b0;
        end else if (!hs_stable_ff) begin
            nxt_stab_cnt = stab_cnt_ff + 16'h0001;
            nxt_hs_stable = (stab_cnt_ff == 16'(STAB_CYC - 1));
        end
    end

    // glitch-free switch: change source only while both clocks are low
    logic sub_half_ff, nxt_sub_half, sub_prev_ff, nxt_sub_prev;
    logic cur_cpu, cur_per, want_cpu, want_per;
    scc_src_t want_cpu_src, want_per_src;
    function automatic logic pick(input scc_src_t s, input logic [2:0] c, input logic sh);
        unique case (s)
            SRC_HS_INT: pick = c[0];
            SRC_HS_SYS: pick = c[1];
            SRC_SUB: pick = sh;
            default: pick = 1'b0;
        endcase
    endfunction
    always_comb begin
        if (proc_clk_ff[B_CPU_SRC]) begin
            want_cpu_src = SRC_SUB;
        end else if (main_mode_ff[B_MAIN_SEL] && main_mode_ff[B_MAIN_MODE]) begin
            want_cpu_src = SRC_HS_SYS;
        end else begin
            want_cpu_src = SRC_HS_INT;
        end
        want_per_src = main_mode_ff[B_MAIN_SEL] ? SRC_HS_SYS : SRC_HS_INT;
        nxt_sub_prev = sync2_ff[2];
        nxt_sub_half = sub_half_ff ^ (sync2_ff[2] && !sub_prev_ff);
        cur_cpu = pick(cpu_src_ff, sync2_ff, sub_half_ff);
        cur_per = pick(per_src_ff, sync2_ff, sub_half_ff);
        want_cpu = pick(want_cpu_src, sync2_ff, sub_half_ff);
        want_per = pick(want_per_src, sync2_ff, sub_half_ff);
        nxt_cpu_src = cpu_src_ff;
        nxt_per_src = per_src_ff;
        if (want_cpu_src != cpu_src_ff && !cur_cpu && !want_cpu) begin
            nxt_cpu_src = want_cpu_src;
        end
        if (want_per_src != per_src_ff && !cur_per && !want_per) begin
            nxt_per_src = want_per_src;
        end
    end

    // low-speed divider producing the watchdog count clock
    logic [15:0] ls_cnt_ff, nxt_ls_cnt;
    logic ls_clk_ff, nxt_ls_clk;
    always_comb begin
        nxt_ls_cnt = ls_cnt_ff;
        nxt_ls_clk = ls_clk_ff;
        if (ls_run_ff) begin
            if (ls_cnt_ff == 16'(LS_HALF_CYC - 1)) begin
                nxt_ls_cnt = 16'h0000;
                nxt_ls_clk = !ls_clk_ff;
            end else begin
                nxt_ls_cnt = ls_cnt_ff + 16'h0001;
            end
        end
    end

    scc_clk_out_t clks_ff, nxt_clks;
    always_comb begin
        nxt_clks.cpu_clk = pick(cpu_src_ff, sync2_ff, sub_half_ff);
        nxt_clks.per_clk = pick(per_src_ff, sync2_ff, sub_half_ff);
        nxt_clks.wdt_clk = ls_clk_ff;
        nxt_clks.tmh1_clk = ls_clk_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_ff <= '0;
            hs_run_ff <= 1'b1;
            ls_run_ff <= 1'b1;
            stab_cnt_ff <= 16'h0000;
            hs_stable_ff <= 1'b0;
            sub_half_ff <= 1'b0;
            sub_prev_ff <= 1'b0;
            cpu_src_ff <= SRC_HS_INT;
            per_src_ff <= SRC_HS_INT;
            ls_cnt_ff <= 16'h0000;
            ls_clk_ff <= 1'b0;
            clks_ff <= '0;
        end else begin
            pins_ff <= nxt_pins;
            hs_run_ff <= nxt_hs_run;
            ls_run_ff <= nxt_ls_run;
            stab_cnt_ff <= nxt_stab_cnt;
            hs_stable_ff <= nxt_hs_stable;
            sub_half_ff <= nxt_sub_half;
            sub_prev_ff <= nxt_sub_prev;
            cpu_src_ff <= nxt_cpu_src;
            per_src_ff <= nxt_per_src;
            ls_cnt_ff <= nxt_ls_cnt;
            ls_clk_ff <= nxt_ls_clk;
            clks_ff <= nxt_clks;
        end
    end
    assign pins_o = pins_ff;
    assign clks_o = clks_ff;
    assign hs_int_osc_run_o = hs_run_ff;
    assign ls_osc_run_o = ls_run_ff;
endmodule

// ### logic/scc_pkg.sv
// package: register map, field positions, reset values and carriers of the clock select block
package scc_pkg;
    // register offsets (byte addresses)
    localparam logic [3:0] OFF_OSC_MODE = 4'h0;   // osc_mode_select_reg
    localparam logic [3:0] OFF_MAIN_OSC = 4'h4;   // main_osc_ctrl_reg
    localparam logic [3:0] OFF_MAIN_MODE = 4'h8;  // main_clock_mode_reg
    localparam logic [3:0] OFF_PROC_CLK = 4'hC;   // processor_clock_ctrl
    localparam logic [4:0] OFF_INT_OSC = 5'h10;   // internal_osc_mode_reg
    localparam logic [4:0] ADDR_TOP = 5'h10;
    // osc_mode_select_reg fields
    localparam int B_MAIN_EXT = 7;
    localparam int B_MAIN_PIN_EN = 6;
    localparam int B_SUB_EXT = 5;
    localparam int B_SUB_EN = 4;
    localparam int B_AMP_HIGH = 0;
    // main_osc_ctrl_reg
    localparam int B_MAIN_STOP = 7;
    // main_clock_mode_reg
    localparam int B_MAIN_FLAG = 5;
    localparam int B_MAIN_SEL = 2;
    localparam int B_MAIN_MODE = 0;
    // processor_clock_ctrl
    localparam int B_SUB_START = 6;
    localparam int B_SUB_FLAG = 5;
    localparam int B_CPU_SRC = 4;
    localparam int B_DIV_HI = 2;
    // internal_osc_mode_reg
    localparam int B_HS_STABLE = 7;
    localparam int B_LS_STOP = 1;
    localparam int B_HS_STOP = 0;
    // reset values
    localparam logic [7:0] RST_OSC_MODE = 8'h00;
    localparam logic [7:0] RST_MAIN_OSC = 8'h80;
    localparam logic [7:0] RST_MAIN_MODE = 8'h00;
    localparam logic [7:0] RST_PROC_CLK = 8'h01;
    localparam logic [7:0] RST_INT_OSC = 8'h00;
    localparam logic [2:0] DIV_MAX = 3'h4;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int HS_STAB_NS = 2000;
    localparam int HS_STAB_CYC = (HS_STAB_NS * CLK_MHZ + 999) / 1000;
    localparam int LS_FREQ_KHZ = 240;
    localparam int LS_HALF_CYC = (CLK_MHZ * 1000) / (2 * LS_FREQ_KHZ);

    typedef enum logic [1:0] {
        SRC_HS_INT,
        SRC_HS_SYS,
        SRC_SUB
    } scc_src_t;

    typedef struct packed {
        logic sub_in_port;    // crystal-in pin left as general port
        logic sub_crystal;    // oscillation amplifier on
        logic sub_ext_input;  // external clock accepted on second pin
        logic main_osc_run;
        logic main_ext_input;
        logic amp_gain_high;
    } scc_pin_ctrl_t;

    typedef struct packed {
        logic cpu_clk;
        logic per_clk;
        logic wdt_clk;
        logic tmh1_clk;
    } scc_clk_out_t;
endpackage

// ### test/scc_clock_select_asserts.sv
// port-level assertion checker for the clock select block
`timescale 1ns/1ns
module scc_clock_select_chk #(
    parameter int STAB_CYC = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic stop_mode_i,
    input wire logic ls_fixed_i,
    input wire scc_pkg::scc_pin_ctrl_t pins_o,
    input wire scc_pkg::scc_clk_out_t clks_o,
    input wire logic hs_int_osc_run_o,
    input wire logic ls_osc_run_o
);
    import scc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence rd_of(a);
        wb_ack_o && !wb_we_i && wb_adr_i[4:0] == a;
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    ext_port_a: assert property (pins_o.sub_ext_input |-> pins_o.sub_in_port)
        else $error("crystal pin not port in external mode");
    sub_excl_a: assert property (!(pins_o.sub_crystal && pins_o.sub_ext_input))
        else $error("crystal and external both on");
    stop_keep_a: assert property (stop_mode_i && !wb_cyc_i && !wb_ack_o |=> $stable(pins_o))
        else $error("stop mode changed pins");
    ls_fixed_a: assert property (ls_fixed_i |-> ls_osc_run_o)
        else $error("fixed low-speed oscillator stopped");
    wdt_hold_a: assert property (!ls_osc_run_o [*3] |=> $stable(clks_o.wdt_clk))
        else $error("watchdog clock moves while stopped");
    div_legal_a: assert property (rd_of(OFF_PROC_CLK) |-> wb_dat_o[2:0] <= DIV_MAX)
        else $error("prohibited divider held");
    stable_run_a: assert property (
        rd_of(OFF_INT_OSC) ##0 wb_dat_o[B_HS_STABLE] |-> hs_int_osc_run_o)
        else $error("stable flag while stopped");
endmodule

bind scc_clock_select scc_clock_select_chk #(.STAB_CYC(STAB_CYC)) i_chk (.clk_i, .rst_i,
    .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .stop_mode_i,
    .ls_fixed_i, .pins_o, .clks_o, .hs_int_osc_run_o, .ls_osc_run_o);

// ### test/scc_clock_select_bench.sv
// self-checking bench for the clock select block
`timescale 1ns/1ns
module scc_clock_select_bench;
    import scc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'h1;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
    logic hs_int_clk_i = 1'b0, hs_sys_clk_i = 1'b0, sub_clk_i = 1'b0;
    logic ls_fixed_i = 1'b0, stop_mode_i = 1'b0, hs_int_osc_run_o, ls_osc_run_o;
    scc_pin_ctrl_t pins_o;
    scc_clk_out_t clks_o;
    int fail_count = 0, cmp_count = 0, cyc_n = 0;
    scc_clock_select #(.STAB_CYC(4)) i_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .hs_int_clk_i, .hs_sys_clk_i,
        .sub_clk_i, .ls_fixed_i, .stop_mode_i, .pins_o, .clks_o, .hs_int_osc_run_o,
        .ls_osc_run_o);
    always #4 clk_i = ~clk_i;
    // source clocks: high phases of 3, 5 and 7 cycles
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        hs_int_clk_i <= cyc_n % 6 < 3;
        hs_sys_clk_i <= cyc_n % 10 < 5;
        sub_clk_i <= cyc_n % 14 < 7;
        if (cyc_n == 30000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(logic [4:0] a, logic we, logic [7:0] d);
        wb_adr_i <= {27'h0, a};
        wb_we_i <= we;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdc(string nm, logic [4:0] a, logic [7:0] e);
        wb(a, 1'b0, 8'h00);
        chk(nm, rd, {24'h0, e});
    endtask
    // length of a whole high phase of clock output b
    task automatic phase(int b, int e, string nm);
        int l;
        l = 0;
        repeat (2) begin
            while (clks_o[b] !== 1'b0) @(posedge clk_i);
            while (clks_o[b] !== 1'b1) @(posedge clk_i);
        end
        while (clks_o[b] === 1'b1) begin
            l++;
            @(posedge clk_i);
        end
        chk(nm, l, e);
    endtask
    task automatic t_reset();
        rdc("osc_mode", OFF_OSC_MODE, RST_OSC_MODE);
        rdc("main_osc", OFF_MAIN_OSC, RST_MAIN_OSC);
        wb(OFF_MAIN_MODE, 1'b1, 8'h20);
        rdc("main_mode", OFF_MAIN_MODE, RST_MAIN_MODE);
        rdc("proc_clk", OFF_PROC_CLK, RST_PROC_CLK);
        rdc("int_osc", OFF_INT_OSC, RST_INT_OSC | 8'h80);
        wb(5'h14, 1'b1, 8'hFF);
        rdc("unmapped", 5'h14, 8'h00);
        chk("pins", pins_o, 6'h20);
        phase(3, 3, "cpu_int");
        phase(2, 3, "per_int");
    endtask
    task automatic t_sub();
        logic [2:0] e;
        for (int i = 0; i < 8; i++) begin
            wb(OFF_OSC_MODE, 1'b1, {2'h0, i[1], i[0], 4'h0});
            wb(OFF_PROC_CLK, 1'b1, {1'h0, i[2], 6'h01});
            tick(3);
            e[1] = i[2] | (!i[1] & i[0]);
            e[0] = !i[2] & i[1] & i[0];
            e[2] = !e[1];
            chk("sub_pins", pins_o[5:3], e);
            stop_mode_i <= 1'b1;
            tick(5);
            chk("stop_pins", pins_o[5:3], e);
            stop_mode_i <= 1'b0;
            rdc("sub_flag_off", OFF_PROC_CLK, {1'b0, i[2], 6'h01});
            wb(OFF_OSC_MODE, 1'b1, 8'h00);
            wb(OFF_PROC_CLK, 1'b1, 8'h01);
            tick(8);
        end
    endtask
    task automatic t_main();
        wb(OFF_OSC_MODE, 1'b1, 8'h01);
        wb(OFF_OSC_MODE, 1'b1, 8'hC1);
        wb(OFF_MAIN_OSC, 1'b1, 8'h00);
        tick(3);
        chk("main_pins", pins_o[2:0], 3'h7);
        wb(OFF_MAIN_MODE, 1'b1, 8'h04);
        phase(3, 3, "cpu_int_sel");
        phase(2, 5, "per_sys");
        rdc("flag_int", OFF_MAIN_MODE, 8'h04);
        wb(OFF_MAIN_MODE, 1'b1, 8'h05);
        phase(3, 5, "cpu_sys");
        rdc("flag_sys", OFF_MAIN_MODE, 8'h25);
        wb(OFF_INT_OSC, 1'b1, 8'h01);
        tick(3);
        chk("hs_stop", hs_int_osc_run_o, 1'b0);
        rdc("hs_unstable", OFF_INT_OSC, 8'h01);
        wb(OFF_INT_OSC, 1'b1, 8'h00);
        tick(8);
        chk("hs_restart", hs_int_osc_run_o, 1'b1);
        rdc("hs_stable", OFF_INT_OSC, 8'h80);
        wb(OFF_OSC_MODE, 1'b1, 8'hD1);
        tick(3);
        wb(OFF_PROC_CLK, 1'b1, 8'h14);
        phase(3, 14, "cpu_sub");
        phase(2, 5, "per_sys_sub");
        wb(OFF_PROC_CLK, 1'b1, 8'h17);
        rdc("flag_sub", OFF_PROC_CLK, 8'h34);
        wb(OFF_MAIN_MODE, 1'b1, 8'h00);
        phase(2, 3, "per_int_sub");
        wb(OFF_PROC_CLK, 1'b1, 8'h10);
        phase(3, 14, "cpu_sub_div0");
        wb(OFF_PROC_CLK, 1'b1, 8'h01);
        phase(3, 3, "cpu_back");
        rdc("flag_back", OFF_PROC_CLK, 8'h01);
        wb(OFF_MAIN_OSC, 1'b1, 8'h80);
        wb(OFF_OSC_MODE, 1'b1, 8'h00);
        tick(3);
        chk("all_off", pins_o, 6'h20);
    endtask
    task automatic t_ls();
        phase(1, LS_HALF_CYC, "wdt_half");
        phase(0, LS_HALF_CYC, "tmh1_half");
        wb(OFF_INT_OSC, 1'b1, 8'h02);
        tick(3);
        chk("ls_stop", ls_osc_run_o, 1'b0);
        wb(OFF_INT_OSC, 1'b1, 8'h00);
        tick(3);
        chk("ls_run", ls_osc_run_o, 1'b1);
        ls_fixed_i <= 1'b1;
        rst_i <= 1'b1;
        tick(4);
        rst_i <= 1'b0;
        tick(8);
        wb(OFF_INT_OSC, 1'b1, 8'h02);
        tick(3);
        chk("ls_fixed", ls_osc_run_o, 1'b1);
    endtask
    initial begin
        tick(16);
        rst_i <= 1'b0;
        tick(2);
        t_reset();
        t_sub();
        t_main();
        t_ls();
        end_of_test();
    end
endmodule
